// file: core/act_apb_regs.sv
// APB slave holding the configuration and reporting busy, frame and result.
`timescale 1ns/1ps
module act_apb_regs import act_pkg::*; (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Block side
  output act_cfg_t               cfg,
  input  wire act_stat_t         stat
);

  act_cfg_t    cfg_q;
  act_cfg_t    cfg_d;
  logic [31:0] rd_q;
  logic [31:0] rd_d;

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return (a == OFF_CTRL) || (a == OFF_STATUS) || (a == OFF_RESULT);
  endfunction

  // Read data is fetched in the setup cycle so the access phase needs no wait state.
  always_comb begin
    cfg_d = cfg_q;
    rd_d  = rd_q;
    if (psel && !penable) begin
      rd_d = 32'h0000_0000;
      if (paddr == OFF_CTRL) begin
        rd_d[CTRL_MODE_LSB +: 2] = cfg_q.mode;
        rd_d[CTRL_DIV_LSB +: 2]  = cfg_q.div;
        rd_d[CTRL_CODE_BIT]      = cfg_q.coding;
        rd_d[CTRL_SWAP_BIT]      = cfg_q.swap;
      end else if (paddr == OFF_STATUS) begin
        rd_d[STAT_BUSY_BIT]  = stat.busy;
        rd_d[STAT_FRAME_BIT] = stat.frame;
      end else if (paddr == OFF_RESULT) begin
        rd_d[RES_W-1:0] = stat.result;
      end
    end
    if (psel && penable && pwrite && (paddr == OFF_CTRL)) begin
      cfg_d.mode   = act_mode_t'(pwdata[CTRL_MODE_LSB +: 2]);
      cfg_d.div    = pwdata[CTRL_DIV_LSB +: 2];
      cfg_d.coding = pwdata[CTRL_CODE_BIT];
      cfg_d.swap   = pwdata[CTRL_SWAP_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= CFG_RST;
      rd_q  <= 32'h0000_0000;
    end else begin
      cfg_q <= cfg_d;
      rd_q  <= rd_d;
    end
  end

  assign cfg     = cfg_q;
  assign prdata  = rd_q;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);

endmodule

// file: core/act_core.sv
// Conversion sequencer with parallel and serial result readout.
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module act_core import act_pkg::*; #(
  parameter int CONV_CYCLES = CONV_CYC
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Conversion control pins
  input  wire logic              convert_start_n,
  input  wire logic              conv_reset,
  input  wire logic              chip_select_n,
  input  wire logic              read_n,
  output logic                   busy,
  // Converter core result
  input  wire logic [RES_W-1:0]  sample_code,
  // Parallel bus
  output logic      [RES_W-1:0]  data_out,
  output logic                   data_oe,
  // Serial port
  input  wire logic              serial_clock_in,
  input  wire logic              serial_data_in,
  output logic                   serial_clock_out,
  output logic                   serial_clock_oe,
  output logic                   word_frame,
  output logic                   word_frame_oe,
  output logic                   serial_data_out,
  output logic                   serial_data_oe
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  localparam int SHIFT0 = lead_cyc(0) + 2 * RES_W * half_cyc(0) + tail_cyc(0);

  if (CONV_CYCLES < 1 || SYNC_CYC + CONV_CYCLES + EOC_BUSY_CYC > BUSY_MAX_CYC) begin : g_bad_conv
    $error("Conversion count does not fit the busy window.");
  end
  if (SYNC_CYC + CONV_CYCLES > DATA_VALID_CYC) begin : g_bad_valid
    $error("Conversion count does not fit the data valid window.");
  end
  if (SYNC_CYC > BUSY_RISE_MAX_CYC) begin : g_bad_rise
    $error("Start detection is too slow for the busy rise limit.");
  end
  for (genvar c = 0; c < 4; c++) begin : g_div_chk
    localparam int PER = 2 * half_cyc(c) * CLK_PERIOD_NS;
    localparam int TOT = SYNC_CYC + CONV_CYCLES + lead_cyc(c) + 2 * RES_W * half_cyc(c)
                         + tail_cyc(c) + FRAME_BUSY_CYC;
    if (PER < SCLK_PER_MIN_NS[c] || PER > SCLK_PER_MAX_NS[c]) begin : g_bad_per
      $error("Serial clock period out of range for a divide code.");
    end
    if (TOT > floor_cyc(BUSY_AFTER_NS[c])) begin : g_bad_busy
      $error("Read-after-convert sequence exceeds the busy maximum.");
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers and configuration registers
  // ----------------------------------------------------------------
  act_pin_t  pin_s;
  act_cfg_t  cfg;
  act_stat_t stat;

  act_sync #(
    .W       ($bits(act_pin_t)),
    .RST_VAL (PIN_RST)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({convert_start_n, chip_select_n, read_n, conv_reset,
                serial_clock_in, serial_data_in}),
    .q       (pin_s)
  );

  act_apb_regs u_regs (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .cfg     (cfg),
    .stat    (stat)
  );

  // ----------------------------------------------------------------
  // Edge detection on synchronised pins
  // ----------------------------------------------------------------
  logic cnv_prev_q;
  logic sclk_prev_q;
  logic start;
  logic sclk_rise;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnv_prev_q  <= 1'b1;
      sclk_prev_q <= 1'b0;
    end else begin
      cnv_prev_q  <= pin_s.cnv_n;
      sclk_prev_q <= pin_s.sclk;
    end
  end

  assign start     = cnv_prev_q && !pin_s.cnv_n;
  assign sclk_rise = !sclk_prev_q && pin_s.sclk;

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  act_cst_t         cst_q;
  act_cst_t         cst_d;
  logic [15:0]      ccnt_q;
  logic [15:0]      ccnt_d;
  logic [RES_W-1:0] res_q;
  logic [RES_W-1:0] res_d;
  logic [RES_W-1:0] par_q;
  logic [RES_W-1:0] par_d;
  logic             go_after;
  logic             slave_load;
  logic             ser_done;

  function automatic logic [RES_W-1:0] coded(input logic [RES_W-1:0] s, input logic bin);
    return bin ? s : {~s[RES_W-1], s[RES_W-2:0]};
  endfunction

  always_comb begin
    cst_d      = cst_q;
    ccnt_d     = ccnt_q;
    res_d      = res_q;
    par_d      = par_q;
    go_after   = 1'b0;
    slave_load = 1'b0;
    if (pin_s.rst) begin
      cst_d = C_IDLE;
    end else begin
      unique case (cst_q)
        C_IDLE: begin
          if (start) begin
            cst_d  = C_CONV;
            ccnt_d = 16'(CONV_CYCLES - 1);
          end
        end
        C_CONV: begin
          if (ccnt_q == 16'h0000) begin
            res_d = coded(sample_code, cfg.coding);
            par_d = cfg.swap ? {res_d[7:0], res_d[15:8]} : res_d;
            if (cfg.mode == MODE_AFTER) begin
              cst_d    = C_SER;
              go_after = 1'b1;
            end else begin
              cst_d      = C_HOLD;
              ccnt_d     = 16'(EOC_BUSY_CYC - 1);
              slave_load = (cfg.mode == MODE_SLAVE);
            end
          end else begin
            ccnt_d = ccnt_q - 16'h0001;
          end
        end
        C_SER: begin
          if (ser_done) begin
            cst_d  = C_HOLD;
            ccnt_d = 16'(FRAME_BUSY_CYC - 1);
          end
        end
        C_HOLD: begin
          if (ccnt_q == 16'h0000) begin
            cst_d = C_IDLE;
          end else begin
            ccnt_d = ccnt_q - 16'h0001;
          end
        end
        default: cst_d = C_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cst_q  <= C_IDLE;
      ccnt_q <= 16'h0000;
      res_q  <= 16'h0000;
      par_q  <= 16'h0000;
    end else begin
      cst_q  <= cst_d;
      ccnt_q <= ccnt_d;
      res_q  <= res_d;
      par_q  <= par_d;
    end
  end

  // ----------------------------------------------------------------
  // Serial shifter
  // ----------------------------------------------------------------
  act_sst_t         sst_q;
  act_sst_t         sst_d;
  logic [15:0]      scnt_q;
  logic [15:0]      scnt_d;
  logic [4:0]       bits_q;
  logic [4:0]       bits_d;
  logic [1:0]       sdiv_q;
  logic [1:0]       sdiv_d;
  logic             sclk_q;
  logic             sclk_d;
  logic             frame_q;
  logic             frame_d;
  logic [RES_W-1:0] shift_q;
  logic [RES_W-1:0] shift_d;
  logic             go_during;

  // Read-during-convert sends the previous result with the fastest clock timing.
  assign go_during = start && (cfg.mode == MODE_DURING) && !pin_s.rst;

  always_comb begin
    sst_d    = sst_q;
    scnt_d   = scnt_q;
    bits_d   = bits_q;
    sdiv_d   = sdiv_q;
    sclk_d   = sclk_q;
    frame_d  = frame_q;
    shift_d  = shift_q;
    ser_done = 1'b0;
    unique case (sst_q)
      S_IDLE: begin
        if (go_after || go_during) begin
          sst_d   = S_LEAD;
          frame_d = 1'b1;
          sdiv_d  = go_after ? cfg.div : 2'h0;
          shift_d = go_after ? res_d : res_q;
          bits_d  = 5'(RES_W - 1);
          scnt_d  = 16'(lead_cyc(go_after ? int'(cfg.div) : 0) - 1);
        end else if (slave_load) begin
          shift_d = res_d;
        end else if (sclk_rise && cfg.mode == MODE_SLAVE) begin
          shift_d = {shift_q[RES_W-2:0], pin_s.sdi};
        end
      end
      S_LEAD: begin
        if (scnt_q == 16'h0000) begin
          sst_d  = S_SHIFT;
          sclk_d = 1'b1;
          scnt_d = 16'(half_cyc(int'(sdiv_q)) - 1);
        end else begin
          scnt_d = scnt_q - 16'h0001;
        end
      end
      S_SHIFT: begin
        if (scnt_q == 16'h0000) begin
          sclk_d = !sclk_q;
          scnt_d = 16'(half_cyc(int'(sdiv_q)) - 1);
          if (sclk_q) begin
            if (bits_q == 5'h00) begin
              sst_d  = S_TAIL;
              sclk_d = 1'b0;
              scnt_d = 16'(tail_cyc(int'(sdiv_q)) - 1);
            end else begin
              shift_d = {shift_q[RES_W-2:0], 1'b0};
              bits_d  = bits_q - 5'h01;
            end
          end
        end else begin
          scnt_d = scnt_q - 16'h0001;
        end
      end
      S_TAIL: begin
        if (scnt_q == 16'h0000) begin
          sst_d    = S_IDLE;
          frame_d  = 1'b0;
          ser_done = 1'b1;
        end else begin
          scnt_d = scnt_q - 16'h0001;
        end
      end
      default: begin
        sst_d   = S_IDLE;
        sclk_d  = 1'b0;
        frame_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sst_q   <= S_IDLE;
      scnt_q  <= 16'h0000;
      bits_q  <= 5'h00;
      sdiv_q  <= 2'h0;
      sclk_q  <= 1'b0;
      frame_q <= 1'b0;
      shift_q <= 16'h0000;
    end else begin
      sst_q   <= sst_d;
      scnt_q  <= scnt_d;
      bits_q  <= bits_d;
      sdiv_q  <= sdiv_d;
      sclk_q  <= sclk_d;
      frame_q <= frame_d;
      shift_q <= shift_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Enables follow the synchronised select directly, adding no extra flop delay.
  logic cs_on;
  logic master;

  assign cs_on  = !pin_s.cs_n;
  assign master = (cfg.mode == MODE_AFTER) || (cfg.mode == MODE_DURING);

  assign busy             = (cst_q != C_IDLE);
  assign data_out         = par_q;
  assign data_oe          = cs_on && !pin_s.rd_n && (cfg.mode == MODE_PARALLEL);
  assign serial_clock_out = sclk_q;
  assign serial_clock_oe  = cs_on && master;
  assign word_frame       = frame_q;
  assign word_frame_oe    = cs_on && master;
  assign serial_data_out  = shift_q[RES_W-1];
  assign serial_data_oe   = cs_on && (cfg.mode != MODE_PARALLEL);

  assign stat = '{busy: busy, frame: frame_q, result: res_q};

endmodule

// file: core/act_pkg.sv
// Shared constants, timing figures and types of the conversion and readout block.
// How it works
// - Busy rises within 35 ns of convert_start_n falling.
// - Outside master read-after-convert, busy stays high at most 1.25 us.
// - Busy falls at least 10 ns after the conversion ends.
// - Parallel result is valid within 1.25 us of convert_start_n falling.
// - Parallel result is valid at least 12 ns before busy falls.
// - Master frame precedes first serial clock edge, at least 3 ns during convert.
// - Divide select 00..11 gives clock periods 25/50/100/200 to 40/70/140/280 ns; read-during-convert always uses 00.
// - Read-after-convert busy maximum is 2, 2.5, 3.5, 5.75 us by divide code.
// - Frame holds after last clock edge 3, 55, 130 or 290 ns by code.
// - Read-after-convert frame drops about 25 ns before busy falls.
// - Read-after-convert frame asserts only once the conversion completes.
// - Chip select high releases data, frame and clock outputs within 10 ns.
// - Each result is one 16-bit word, parallel or serial.
// - A result is readable as soon as its conversion ends.
// - Coding select high gives straight binary, low inverts the top bit.
// - Byte order low puts low byte on lines 7..0, high swaps lanes.
package act_pkg;

  // ----------------------------------------------------------------
  // Clock and conversion timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;

  function automatic int ceil_cyc(input int ns);
    return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction

  function automatic int floor_cyc(input int ns);
    return ns / CLK_PERIOD_NS;
  endfunction

  localparam int RES_W              = 16;
  localparam int SYNC_CYC           = 3;
  localparam int T_BUSY_RISE_MAX_NS = 35;
  localparam int BUSY_RISE_MAX_CYC  = floor_cyc(T_BUSY_RISE_MAX_NS);
  localparam int T_BUSY_MAX_NS      = 1250;
  localparam int BUSY_MAX_CYC       = floor_cyc(T_BUSY_MAX_NS);
  localparam int T_DATA_VALID_NS    = 1250;
  localparam int DATA_VALID_CYC     = floor_cyc(T_DATA_VALID_NS);
  localparam int T_CONV_NS          = 1200;
  localparam int CONV_CYC           = floor_cyc(T_CONV_NS);
  localparam int T_EOC_BUSY_NS      = 10;
  localparam int T_DATA_BUSY_NS     = 12;
  localparam int EOC_BUSY_CYC       = (ceil_cyc(T_DATA_BUSY_NS) > ceil_cyc(T_EOC_BUSY_NS)) ?
                                      ceil_cyc(T_DATA_BUSY_NS) : ceil_cyc(T_EOC_BUSY_NS);
  localparam int T_FRAME_BUSY_NS    = 25;
  localparam int FRAME_BUSY_CYC     = ceil_cyc(T_FRAME_BUSY_NS);

  // ----------------------------------------------------------------
  // Serial clock figures indexed by divide select code
  // ----------------------------------------------------------------
  localparam int SCLK_PER_MIN_NS [4] = '{25, 50, 100, 200};
  localparam int SCLK_PER_MAX_NS [4] = '{40, 70, 140, 280};
  localparam int LEAD_MIN_NS     [4] = '{3, 17, 17, 17};
  localparam int TAIL_MIN_NS     [4] = '{3, 55, 130, 290};
  localparam int BUSY_AFTER_NS   [4] = '{2000, 2500, 3500, 5750};

  function automatic int half_cyc(input int code);
    return ceil_cyc((SCLK_PER_MIN_NS[code] + 1) / 2);
  endfunction

  function automatic int lead_cyc(input int code);
    return ceil_cyc(LEAD_MIN_NS[code]);
  endfunction

  function automatic int tail_cyc(input int code);
    return ceil_cyc(TAIL_MIN_NS[code]);
  endfunction

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W         = 12;
  localparam logic [11:0] OFF_CTRL       = 12'h000;
  localparam logic [11:0] OFF_STATUS     = 12'h004;
  localparam logic [11:0] OFF_RESULT     = 12'h008;
  localparam int          CTRL_MODE_LSB  = 0;
  localparam int          CTRL_DIV_LSB   = 2;
  localparam int          CTRL_CODE_BIT  = 4;
  localparam int          CTRL_SWAP_BIT  = 5;
  localparam int          STAT_BUSY_BIT  = 0;
  localparam int          STAT_FRAME_BIT = 1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_PARALLEL = 2'h0,
    MODE_AFTER    = 2'h1,
    MODE_DURING   = 2'h2,
    MODE_SLAVE    = 2'h3
  } act_mode_t;

  typedef struct packed {
    act_mode_t  mode;
    logic [1:0] div;
    logic       coding;
    logic       swap;
  } act_cfg_t;

  localparam act_cfg_t CFG_RST = '{mode: MODE_PARALLEL, div: 2'h0, coding: 1'b1, swap: 1'b0};

  typedef struct packed {
    logic             busy;
    logic             frame;
    logic [RES_W-1:0] result;
  } act_stat_t;

  typedef struct packed {
    logic cnv_n;
    logic cs_n;
    logic rd_n;
    logic rst;
    logic sclk;
    logic sdi;
  } act_pin_t;

  localparam act_pin_t PIN_RST = '{cnv_n: 1'b1, cs_n: 1'b1, rd_n: 1'b1, rst: 1'b0,
                                   sclk: 1'b0, sdi: 1'b0};

  typedef enum logic [3:0] {
    C_IDLE = 4'h1,
    C_CONV = 4'h2,
    C_SER  = 4'h4,
    C_HOLD = 4'h8
  } act_cst_t;

  typedef enum logic [3:0] {
    S_IDLE  = 4'h1,
    S_LEAD  = 4'h2,
    S_SHIFT = 4'h4,
    S_TAIL  = 4'h8
  } act_sst_t;

endpackage

// file: core/act_sync.sv
// Two-flop synchroniser for pin inputs.
`timescale 1ns/1ps
module act_sync #(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

// file: verification/act_core_sva.sv
// Port-level timing checker of the conversion and readout block.
`timescale 1ns/1ps
module act_core_sva import act_pkg::*; #(
  parameter int CONV_CYCLES = 8
) (
  // Clock, reset and pins
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             convert_start_n,
  input wire logic             conv_reset,
  input wire logic             chip_select_n,
  input wire logic             busy,
  input wire logic [RES_W-1:0] data_out,
  // Serial port
  input wire logic             serial_clock_out,
  input wire logic             serial_clock_oe,
  input wire logic             word_frame,
  input wire logic             word_frame_oe,
  input wire logic             serial_data_oe
);
  localparam int BUSY_AFTER_CYC = 1150;
  logic [11:0] bcnt_q;
  logic        fseen_q;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // Busy length, with frame history so read-after-convert is exempt
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bcnt_q  <= 12'h000;
      fseen_q <= 1'b0;
    end else begin
      bcnt_q  <= busy ? bcnt_q + 12'h001 : 12'h000;
      fseen_q <= busy && (fseen_q || word_frame);
    end
  end
  a_busy_rise: assert property ($fell(convert_start_n) && !busy && !word_frame
    && !conv_reset |-> ##[1:7] busy) else $error("busy late after start");
  a_busy_width: assert property (busy && !fseen_q && !word_frame
    |-> bcnt_q < CONV_CYCLES + 10) else $error("busy too long");
  a_busy_after: assert property (busy |-> bcnt_q < BUSY_AFTER_CYC)
    else $error("busy too long in serial master");
  a_data_hold: assert property (busy && $changed(data_out) |-> busy[*3])
    else $error("busy fell too soon after result");
  a_sclk_frame: assert property ($rose(serial_clock_out)
    |-> word_frame && $past(word_frame)) else $error("serial clock outside frame");
  a_frame_lead: assert property ($rose(word_frame) |-> !serial_clock_out)
    else $error("clock high at frame start");
  // Only a frame that ends after the conversion belongs to read-after-convert.
  a_frame_busy: assert property ($fell(word_frame) && busy && bcnt_q > CONV_CYCLES
    |-> busy[*3] ##[1:4] !busy) else $error("busy fall not after frame");
  a_frame_conv: assert property ($rose(word_frame) && $past(busy)
    |-> bcnt_q >= CONV_CYCLES - 1) else $error("frame before conversion end");
  a_cs_release: assert property ($rose(chip_select_n)
    |-> ##[1:5] !(serial_data_oe || word_frame_oe || serial_clock_oe))
    else $error("serial outputs not released");
  c_busy: cover property ($fell(busy));
  c_frame: cover property ($fell(word_frame) && busy);
  c_cs: cover property ($rose(chip_select_n));
endmodule
bind act_core act_core_sva #(.CONV_CYCLES(CONV_CYCLES)) u_act_core_sva (
  .pclk(pclk), .presetn(presetn), .convert_start_n(convert_start_n),
  .conv_reset(conv_reset), .chip_select_n(chip_select_n), .busy(busy),
  .data_out(data_out), .serial_clock_out(serial_clock_out),
  .serial_clock_oe(serial_clock_oe), .word_frame(word_frame),
  .word_frame_oe(word_frame_oe), .serial_data_oe(serial_data_oe));

// file: verification/act_host_rx.sv
// Host serial receiver that captures words and measures clock timing.
`timescale 1ns/1ps
module act_host_rx (
  // Clock and wires
  input wire logic pclk,
  input wire logic sclk,
  input wire logic frame,
  input wire logic sdo,
  // Captured word, bit count and timings in pclk cycles
  output logic [15:0] word,
  output int          nbits,
  output int          lead,
  output int          per,
  output int          tail
);
  logic sclk_q = 1'b0;
  logic frm_q  = 1'b0;
  int   c_rise = 0;
  int   c_fall = 0;
  // Bits are taken on the rising clock, MSB first, as a real shift register would.
  always @(posedge pclk) begin
    sclk_q <= sclk;
    frm_q  <= frame;
    c_rise <= c_rise + 1;
    c_fall <= c_fall + 1;
    if (frame && !frm_q) begin
      nbits  <= 0;
      c_rise <= 1;
    end
    if (sclk && !sclk_q) begin
      if (nbits == 0) lead <= c_rise;
      else per <= c_rise;
      word   <= {word[14:0], sdo};
      nbits  <= nbits + 1;
      c_rise <= 1;
    end
    if (!sclk && sclk_q) c_fall <= 1;
    if (!frame && frm_q) tail <= c_fall;
  end
endmodule

// file: verification/test_act_core.sv
// Random and directed test of conversion, parallel and serial readout.
`timescale 1ns/1ps
module test_act_core import act_pkg::*; ();
  localparam int CC = 8;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic        cnv_n, c_rst, cs_n, rd_n, busy, sci, sdi, sco, sco_oe;
  logic        frm, frm_oe, sdo, sdo_oe, data_oe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [15:0] code, dout, word, prev, got;
  int          nbits, lead, per, tail, err_count, total_checks;
  act_core #(.CONV_CYCLES(CC)) u_act_core (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .convert_start_n(cnv_n), .conv_reset(c_rst),
    .chip_select_n(cs_n), .read_n(rd_n), .busy(busy), .sample_code(code),
    .data_out(dout), .data_oe(data_oe), .serial_clock_in(sci), .serial_data_in(sdi),
    .serial_clock_out(sco), .serial_clock_oe(sco_oe), .word_frame(frm),
    .word_frame_oe(frm_oe), .serial_data_out(sdo), .serial_data_oe(sdo_oe));
  act_host_rx u_act_host_rx (.pclk(pclk), .sclk(sco_oe & sco), .frame(frm_oe & frm),
    .sdo(sdo), .word(word), .nbits(nbits), .lead(lead), .per(per), .tail(tail));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] expv(input logic [15:0] c, input logic cod, input logic sw);
    logic [15:0] v;
    v = cod ? c : c ^ 16'h8000;
    return sw ? {v[7:0], v[15:8]} : v;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 100) begin
      n++;
      @(posedge pclk);
    end
    if (n >= 100) chk("apb_wait", 32'h0, 32'h1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // The pulse lasts three cycles so the two-flop synchroniser always sees it.
  task automatic conv();
    int n;
    n = 0;
    seed = nxt(seed);
    code <= seed[15:0];
    cnv_n <= 1'b0;
    repeat (3) @(posedge pclk);
    cnv_n <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while ((busy !== 1'b0 || frm !== 1'b0) && n < 2000);
    if (n >= 2000) chk("conv_wait", 32'h0, 32'h1);
    repeat (400) @(posedge pclk);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge pclk);
    err_count++;
    results();
  end
  initial begin
    {presetn, psel, penable, pwrite, c_rst, sci, sdi, cs_n, rd_n} = '0;
    {paddr, pwdata, code} = '0;
    cnv_n = 1'b1;
    seed = 32'h0001_0456;
    err_count = 0;
    total_checks = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("busy_rst", 32'h0, busy);
    apb(1'b0, OFF_CTRL, 32'h0);
    chk("ctrl_rst", 32'h0000_0010, rd);
    apb(1'b0, 12'h0FC, 32'h0);
    chk("slverr", 32'h1, perr);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, OFF_CTRL, {26'h0, i[1], i[0], 4'h0});
      conv();
      chk("data_out", expv(code, i[0], i[1]), dout);
      chk("data_oe", 32'h1, data_oe);
      apb(1'b0, OFF_RESULT, 32'h0);
      chk("result", expv(code, i[0], 1'b0), rd);
    end
    $display("test parallel done");
    for (int d = 0; d < 4; d++) begin
      apb(1'b1, OFF_CTRL, {26'h0, 2'b01, d[1:0], 2'b01});
      conv();
      chk("ser_word", code, word);
      chk("ser_bits", 32'd16, nbits);
      chk("per_min", 32'h1, 5 * per >= SCLK_PER_MIN_NS[d]);
      chk("per_max", 32'h1, 5 * per <= SCLK_PER_MAX_NS[d]);
      chk("lead", 32'h1, 5 * lead >= LEAD_MIN_NS[d]);
      chk("tail", 32'h1, 5 * tail >= TAIL_MIN_NS[d]);
    end
    cs_n <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("oe_off", 32'h0, {sdo_oe, frm_oe, sco_oe});
    cs_n <= 1'b0;
    $display("test master after done");
    prev = code;
    apb(1'b1, OFF_CTRL, 32'h0000_0012);
    conv();
    chk("during_word", prev, word);
    chk("during_lead", 32'h1, 5 * lead >= LEAD_MIN_NS[0]);
    $display("test master during done");
    apb(1'b1, OFF_CTRL, 32'h0000_0013);
    conv();
    for (int k = 15; k >= 0; k--) begin
      got[k] = sdo;
      seed = nxt(seed);
      sdi <= seed[0];
      sci <= 1'b1;
      repeat (4) @(posedge pclk);
      sci <= 1'b0;
      repeat (4) @(posedge pclk);
    end
    chk("slave_word", code, got);
    $display("test slave done");
    apb(1'b1, OFF_CTRL, 32'h0000_0010);
    cnv_n <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("abort_start", 32'h1, busy);
    cnv_n <= 1'b1;
    c_rst <= 1'b1;
    repeat (3) @(posedge pclk);
    c_rst <= 1'b0;
    // Looked at one cycle before the unaborted conversion would have ended.
    repeat (3) @(posedge pclk);
    chk("abort_busy", 32'h0, busy);
    $display("test abort done");
    results();
  end
endmodule
